// ### inc/acl_pkg.sv
// shared constants, types and arithmetic for the chop and calibration logic
`default_nettype none
package acl_pkg;
  localparam int          ACL_W         = 16;           // filter word and result width
  localparam int          ACL_NCONV     = 2;            // primary and auxiliary converter
  localparam int          ACL_GAIN_FRAC = 15;           // unity gain is 2**15
  localparam logic [31:0] ACL_UNITY     = 32'h0000_8000; // gain used when the span is unusable
  localparam logic [31:0] ACL_NORM_NUM  = 32'h3fff_8000; // maps the full span to 0x7fff
  localparam logic [7:0]  ACL_RATE_MIN  = 8'h0d;        // fastest decimation word, 13
  localparam logic [7:0]  ACL_RATE_MAX  = 8'hff;        // slowest decimation word, 255
  localparam logic [7:0]  ACL_RATE_RST  = 8'h45;        // decimation word after reset
  // register byte offsets
  localparam logic [7:0]  ACL_OFS_MODE  = 8'h00;
  localparam logic [7:0]  ACL_OFS_STAT  = 8'h04;
  localparam logic [7:0]  ACL_OFS_MASK  = 8'h08;
  localparam logic [7:0]  ACL_OFS_RATE  = 8'h0c;
  localparam logic [7:0]  ACL_OFS_OFF0  = 8'h10;        // offset coefficient, converter i at +8*i
  localparam logic [7:0]  ACL_OFS_GAIN0 = 8'h14;        // gain coefficient, converter i at +8*i
  localparam logic [7:0]  ACL_OFS_OFF1  = 8'h18;        // offset coefficient, auxiliary converter
  localparam logic [7:0]  ACL_OFS_GAIN1 = 8'h1c;        // gain coefficient, auxiliary converter
  localparam logic [7:0]  ACL_OFS_RES0  = 8'h20;        // result, converter i at +4*i
  localparam logic [7:0]  ACL_OFS_RES1  = 8'h24;        // result, auxiliary converter
  // mode register layout
  localparam int          ACL_MODE_EN0  = 4;            // enable of converter i at bit 4+i
  localparam logic [2:0]  ACL_MODE_NORM = 3'h0;         // continuous conversion
  localparam logic [2:0]  ACL_MODE_IZS  = 3'h4;         // internal zero-scale
  localparam logic [2:0]  ACL_MODE_IFS  = 3'h5;         // internal full-scale
  localparam logic [2:0]  ACL_MODE_SZS  = 3'h6;         // system zero-scale
  localparam logic [2:0]  ACL_MODE_SFS  = 3'h7;         // system full-scale
  localparam logic [31:0] ACL_MODE_RST  = 32'h0000_0000;
  // converter input selection
  localparam logic [1:0]  ACL_SEL_PINS  = 2'h0;
  localparam logic [1:0]  ACL_SEL_ZERO  = 2'h1;
  localparam logic [1:0]  ACL_SEL_FULL  = 2'h2;
  localparam logic [1:0]  ACL_RESP_OK   = 2'h0;
  localparam logic [1:0]  ACL_RESP_ERR  = 2'h2;

  // one word from a decimation filter
  typedef struct packed {
    logic             valid;
    logic [ACL_W-1:0] word;
  } acl_filt_s;

  // per-converter sequencer state
  typedef enum logic {ACL_ST_CONV, ACL_ST_CAL} acl_cal_e;

  // mean of this and the previous filter word
  function automatic logic [ACL_W-1:0] acl_avg(input logic [ACL_W-1:0] a, input logic [ACL_W-1:0] b);
    logic signed [ACL_W:0] s;
    s = $signed({a[ACL_W-1], a}) + $signed({b[ACL_W-1], b});
    return s[ACL_W:1];
  endfunction

  // normalized multiplier from raw offset and full-scale readings
  function automatic logic [31:0] acl_norm(input logic [ACL_W-1:0] off, input logic [ACL_W-1:0] gain);
    logic signed [ACL_W:0] span;
    span = $signed({gain[ACL_W-1], gain}) - $signed({off[ACL_W-1], off});
    if (span <= 0) return ACL_UNITY;
    return ACL_NORM_NUM / {15'h0000, span};
  endfunction

  // offset subtracted first, then gain applied, saturated to the word
  function automatic logic [ACL_W-1:0] acl_scale(input logic [ACL_W-1:0] x, input logic [ACL_W-1:0] off,
                                                 input logic [31:0] g);
    logic signed [ACL_W:0]    d;
    logic signed [ACL_W+33:0] p;
    logic signed [ACL_W+33:0] q;
    d = $signed({x[ACL_W-1], x}) - $signed({off[ACL_W-1], off});
    p = d * $signed({1'b0, g});
    q = p >>> ACL_GAIN_FRAC;
    if (q > 32767) return 16'h7fff;
    if (q < -32768) return 16'h8000;
    return q[ACL_W-1:0];
  endfunction

  // byte-strobe merge of a bus write
  function automatic logic [31:0] acl_strb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) if (st[b]) r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction
endpackage
`default_nettype wire

// ### hdl/acl_core.sv
// chop averaging, calibration sequencing and coefficient scaling for two converters
// Functional notes
// - converter input polarity reverses every conversion
// - result is mean of new and previous words
// - first result after two conversions following restart
// - four calibration modes from mode field
// - factory coefficients loaded after reset
// - calibration overwrites coefficients of enabled converters
// - zero-scale result goes to offset coefficient
// - full-scale result goes to gain coefficient
// - internal calibration selects internal zero/full input
// - calibration always runs at slowest rate
// - subtract offset, then multiply by gain
// - coefficients normalized before scaling filter words
// - calibration end sets converter ready flag
// - decimation word spans 13 to 255
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module acl_core
  import acl_pkg::*;
(
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          ce,
  // decimation filter side
  input  wire acl_filt_s [ACL_NCONV-1:0]     filt,
  input  wire logic [ACL_NCONV-1:0]          chan_change,
  input  wire logic [ACL_NCONV-1:0][ACL_W-1:0] fac_off,
  input  wire logic [ACL_NCONV-1:0][ACL_W-1:0] fac_gain,
  output logic [ACL_NCONV-1:0]               chop_pol_reg,
  output logic [ACL_NCONV-1:0][1:0]          in_sel_reg,
  output logic [ACL_NCONV-1:0][7:0]          rate_out_reg,
  output logic                               irq_reg,
  // axi4-lite slave
  input  wire logic [7:0]                    s_awaddr,
  input  wire logic                          s_awvalid,
  output logic                               s_awready,
  input  wire logic [31:0]                   s_wdata,
  input  wire logic [3:0]                    s_wstrb,
  input  wire logic                          s_wvalid,
  output logic                               s_wready,
  output logic [1:0]                         s_bresp,
  output logic                               s_bvalid,
  input  wire logic                          s_bready,
  input  wire logic [7:0]                    s_araddr,
  input  wire logic                          s_arvalid,
  output logic                               s_arready,
  output logic [31:0]                        s_rdata,
  output logic [1:0]                         s_rresp,
  output logic                               s_rvalid,
  input  wire logic                          s_rready
);
  // register file
  logic [31:0]                 mode_reg;       // mode field and enables
  logic [ACL_NCONV-1:0]        stat_reg;       // sticky ready flags
  logic [ACL_NCONV-1:0]        mask_reg;       // interrupt mask
  logic [7:0]                  rate_reg;       // programmed decimation word
  logic [ACL_NCONV-1:0][ACL_W-1:0] off_reg;    // offset coefficients
  logic [ACL_NCONV-1:0][ACL_W-1:0] gain_reg;   // gain coefficients, raw full-scale reading
  logic [ACL_NCONV-1:0][ACL_W-1:0] res_reg;    // corrected results
  // averaging and sequencer state
  logic [ACL_NCONV-1:0][ACL_W-1:0] prev_reg;   // last filter word
  logic [ACL_NCONV-1:0]        have_prev_reg;  // a previous word is usable
  acl_cal_e                    st_reg [ACL_NCONV];
  logic [ACL_NCONV-1:0][1:0]   kind_reg;       // mode low bits of the running calibration
  logic                        load_pend_reg;  // factory load still to do
  // bus capture
  logic                        aw_full_reg;
  logic                        w_full_reg;
  logic [7:0]                  waddr_reg;
  logic [31:0]                 wdata_reg;
  logic [3:0]                  wstrb_reg;

  // write decode
  wire         wr_go    = aw_full_reg & w_full_reg & ~s_bvalid;
  wire         wr_mode  = wr_go & (waddr_reg == ACL_OFS_MODE);
  wire         wr_stat  = wr_go & (waddr_reg == ACL_OFS_STAT);
  wire         wr_mask  = wr_go & (waddr_reg == ACL_OFS_MASK);
  wire         wr_rate  = wr_go & (waddr_reg == ACL_OFS_RATE);
  wire [31:0]  mode_new = acl_strb(mode_reg, wdata_reg, wstrb_reg);
  wire [31:0]  rate_new = acl_strb({24'h000000, rate_reg}, wdata_reg, wstrb_reg);
  wire         mode_cal = mode_new[2];                 // codes 4..7 are the calibrations
  wire [ACL_NCONV-1:0] clr_stat = wr_stat ? wdata_reg[ACL_NCONV-1:0] : '0;

  // per-converter combinational terms
  logic [ACL_NCONV-1:0]            fv;        // accepted filter word
  logic [ACL_NCONV-1:0]            done;      // calibration conversion finished
  logic [ACL_NCONV-1:0]            start;     // calibration started by mode write
  logic [ACL_NCONV-1:0]            wr_off;
  logic [ACL_NCONV-1:0]            wr_gain;
  logic [ACL_NCONV-1:0]            still_cal; // calibration continuing next cycle
  logic [ACL_NCONV-1:0][ACL_W-1:0] avg_w;
  logic [ACL_NCONV-1:0][ACL_W-1:0] corr_w;
  logic [ACL_NCONV-1:0][31:0]      norm_w;
  always_comb begin
    for (int i = 0; i < ACL_NCONV; i++) begin
      fv[i]        = filt[i].valid & mode_reg[ACL_MODE_EN0+i];
      avg_w[i]     = acl_avg(filt[i].word, prev_reg[i]);
      norm_w[i]    = acl_norm(off_reg[i], gain_reg[i]);
      corr_w[i]    = acl_scale(avg_w[i], off_reg[i], norm_w[i]);
      done[i]      = fv[i] & have_prev_reg[i] & (st_reg[i] == ACL_ST_CAL);
      start[i]     = wr_mode & mode_cal & mode_new[ACL_MODE_EN0+i];
      wr_off[i]    = wr_go & (waddr_reg == ACL_OFS_OFF0 + 8'(8*i));
      wr_gain[i]   = wr_go & (waddr_reg == ACL_OFS_GAIN0 + 8'(8*i));
      still_cal[i] = start[i] | ((st_reg[i] == ACL_ST_CAL) & ~done[i]);
    end
  end
  // mode field drops back to normal once the last calibration ends
  wire cal_over = (|done) & ~(|still_cal);

  // read decode, unmapped offsets answer zero with an error
  logic [31:0] rd_mux;
  logic        rd_err;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (s_araddr)
      ACL_OFS_MODE:  rd_mux = mode_reg;
      ACL_OFS_STAT:  rd_mux = 32'({(st_reg[1] == ACL_ST_CAL), (st_reg[0] == ACL_ST_CAL), 2'b00, stat_reg});
      ACL_OFS_MASK:  rd_mux = 32'(mask_reg);
      ACL_OFS_RATE:  rd_mux = {24'h000000, rate_reg};
      ACL_OFS_OFF0:  rd_mux = 32'(off_reg[0]);
      ACL_OFS_GAIN0: rd_mux = 32'(gain_reg[0]);
      ACL_OFS_OFF1:  rd_mux = 32'(off_reg[1]);
      ACL_OFS_GAIN1: rd_mux = 32'(gain_reg[1]);
      ACL_OFS_RES0:  rd_mux = 32'(res_reg[0]);
      ACL_OFS_RES1:  rd_mux = 32'(res_reg[1]);
      default:       rd_err = 1'b1;
    endcase
  end

  // axi4-lite handshakes: one write and one read outstanding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      s_awready   <= 1'b1;
      s_wready    <= 1'b1;
      s_bvalid    <= 1'b0;
      s_bresp     <= ACL_RESP_OK;
      waddr_reg   <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      s_arready   <= 1'b1;
      s_rvalid    <= 1'b0;
      s_rdata     <= 32'h0000_0000;
      s_rresp     <= ACL_RESP_OK;
    end else if (ce) begin
      if (s_awvalid & s_awready) begin
        aw_full_reg <= 1'b1;
        s_awready   <= 1'b0;
        waddr_reg   <= s_awaddr;
      end
      if (s_wvalid & s_wready) begin
        w_full_reg <= 1'b1;
        s_wready   <= 1'b0;
        wdata_reg  <= s_wdata;
        wstrb_reg  <= s_wstrb;
      end
      if (wr_go) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        s_bvalid    <= 1'b1;
        s_bresp     <= ((waddr_reg > ACL_OFS_GAIN1) | (waddr_reg[1:0] != 2'b00)) ? ACL_RESP_ERR : ACL_RESP_OK;
      end
      // both channels reopen only once the response is taken
      if (s_bvalid & s_bready) begin
        s_bvalid  <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
      end
      if (s_arvalid & s_arready) begin
        s_arready <= 1'b0;
        s_rvalid  <= 1'b1;
        s_rdata   <= rd_mux;
        s_rresp   <= rd_err ? ACL_RESP_ERR : ACL_RESP_OK;
      end else if (s_rvalid & s_rready) begin
        s_rvalid  <= 1'b0;
        s_arready <= 1'b1;
      end
    end
  end

  // control registers, flags and interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= ACL_MODE_RST;
      stat_reg <= '0;
      mask_reg <= '0;
      rate_reg <= ACL_RATE_RST;
      irq_reg  <= 1'b0;
    end else if (ce) begin
      if (wr_mode) mode_reg <= {26'h0, mode_new[5:4], 1'b0, mode_new[2:0]};
      else if (cal_over) mode_reg[2:0] <= ACL_MODE_NORM;
      if (wr_mask) mask_reg <= wdata_reg[ACL_NCONV-1:0];
      // values below the fastest word are raised to it
      if (wr_rate) rate_reg <= (rate_new[7:0] < ACL_RATE_MIN) ? ACL_RATE_MIN : rate_new[7:0];
      // a new ready event beats a simultaneous write-one clear
      stat_reg <= (stat_reg & ~clr_stat) | (fv & have_prev_reg);
      irq_reg  <= |(stat_reg & mask_reg);
    end
  end

  // per-converter averaging, sequencing and coefficients
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_pend_reg <= 1'b1;
      for (int i = 0; i < ACL_NCONV; i++) begin
        off_reg[i]       <= '0;
        gain_reg[i]      <= '0;
        res_reg[i]       <= '0;
        prev_reg[i]      <= '0;
        have_prev_reg[i] <= 1'b0;
        st_reg[i]        <= ACL_ST_CONV;
        kind_reg[i]      <= 2'b00;
        chop_pol_reg[i]  <= 1'b0;
        in_sel_reg[i]    <= ACL_SEL_PINS;
        rate_out_reg[i]  <= ACL_RATE_RST;
      end
    end else if (ce) begin
      load_pend_reg <= 1'b0;
      // each converter runs on its own state only
      for (int i = 0; i < ACL_NCONV; i++) begin
        if (load_pend_reg) begin
          off_reg[i]  <= fac_off[i];
          gain_reg[i] <= fac_gain[i];
        end else if (done[i] & ~kind_reg[i][0]) begin
          off_reg[i] <= avg_w[i];
        end else if (done[i]) begin
          gain_reg[i] <= avg_w[i];
        end else begin
          if (wr_off[i])  off_reg[i]  <= wdata_reg[ACL_W-1:0];
          if (wr_gain[i]) gain_reg[i] <= wdata_reg[ACL_W-1:0];
        end
        if (fv[i]) begin
          prev_reg[i]     <= filt[i].word;
          have_prev_reg[i] <= 1'b1;
          chop_pol_reg[i] <= ~chop_pol_reg[i];
          if (have_prev_reg[i] & (st_reg[i] == ACL_ST_CONV)) res_reg[i] <= corr_w[i];
        end
        if (done[i]) st_reg[i] <= ACL_ST_CONV;
        // restart discards the stale word so two conversions pass first
        if (start[i] | chan_change[i] | (wr_mode & ~mode_new[ACL_MODE_EN0+i])) begin
          have_prev_reg[i] <= 1'b0;
        end
        if (start[i]) begin
          st_reg[i]   <= ACL_ST_CAL;
          kind_reg[i] <= mode_new[1:0];
        end
        // only internal calibrations steer the input away from the pins
        if ((st_reg[i] == ACL_ST_CAL) & ~kind_reg[i][1]) begin
          in_sel_reg[i] <= kind_reg[i][0] ? ACL_SEL_FULL : ACL_SEL_ZERO;
        end else begin
          in_sel_reg[i] <= ACL_SEL_PINS;
        end
        rate_out_reg[i] <= (st_reg[i] == ACL_ST_CAL) ? ACL_RATE_MAX : rate_reg;
      end
    end
  end

  // checks on the converter logic
  property p_chop;
    @(posedge aclk) disable iff (!aresetn) (ce & fv[0]) |=> (chop_pol_reg[0] != $past(chop_pol_reg[0]));
  endproperty
  a_chop: assert property (p_chop) else $error("chop polarity did not flip");
  property p_avg;
    @(posedge aclk) disable iff (!aresetn)
      (ce & fv[1] & have_prev_reg[1] & (st_reg[1] == ACL_ST_CONV)) |=> (res_reg[1] == $past(corr_w[1]));
  endproperty
  a_avg: assert property (p_avg) else $error("result is not the corrected average");
  property p_first;
    @(posedge aclk) disable iff (!aresetn) (ce & chan_change[0]) |=> (!have_prev_reg[0] && $stable(stat_reg[0]));
  endproperty
  a_first: assert property (p_first) else $error("restart did not discard the previous word");
  property p_factory;
    @(posedge aclk) disable iff (!aresetn) (ce & load_pend_reg) |=> (off_reg[0] == $past(fac_off[0]) &&
      gain_reg[1] == $past(fac_gain[1]));
  endproperty
  a_factory: assert property (p_factory) else $error("factory coefficients not loaded");
  property p_zero;
    @(posedge aclk) disable iff (!aresetn) (ce & done[0] & !kind_reg[0][0]) |=> (off_reg[0] == $past(avg_w[0]));
  endproperty
  a_zero: assert property (p_zero) else $error("zero-scale result not stored as offset");
  property p_full;
    @(posedge aclk) disable iff (!aresetn) (ce & done[1] & kind_reg[1][0]) |=> (gain_reg[1] == $past(avg_w[1]));
  endproperty
  a_full: assert property (p_full) else $error("full-scale result not stored as gain");
  property p_isel;
    @(posedge aclk) disable iff (!aresetn) (ce & st_reg[0] == ACL_ST_CAL & kind_reg[0] == 2'b00) |=>
      (in_sel_reg[0] == ACL_SEL_ZERO);
  endproperty
  a_isel: assert property (p_isel) else $error("internal zero not selected");
  property p_rate;
    @(posedge aclk) disable iff (!aresetn) (ce & st_reg[1] == ACL_ST_CAL) |=> (rate_out_reg[1] == ACL_RATE_MAX);
  endproperty
  a_rate: assert property (p_rate) else $error("calibration not at slowest rate");
  property p_ready;
    @(posedge aclk) disable iff (!aresetn) (ce & done[0]) |=> stat_reg[0] ##1 (irq_reg | !mask_reg[0] | !ce);
  endproperty
  a_ready: assert property (p_ready) else $error("calibration end not flagged");
  property p_clamp;
    @(posedge aclk) disable iff (!aresetn) (ce & wr_rate & rate_new[7:0] < ACL_RATE_MIN) |=> (rate_reg == ACL_RATE_MIN);
  endproperty
  a_clamp: assert property (p_clamp) else $error("decimation word below fastest");
endmodule
`default_nettype wire

// ### tb/acl_filt_model.sv
// behavioural decimation filter pair that feeds chopped words to the block
`timescale 1ns/1ps
`default_nettype none
module acl_filt_model
  import acl_pkg::*;
#(
  parameter logic [15:0] CHOP_D   = 16'h0100, // offset term that chopping must cancel
  parameter logic [15:0] ZERO_LVL = 16'h0020, // internal zero input level
  parameter logic [15:0] FULL_LVL = 16'h7000  // internal full-scale input level
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [1:0]       go,       // one word per pulse
  input  wire logic [1:0][15:0] pin_lvl,  // voltage at the pins, set by the system
  input  wire logic [1:0]       chop_pol, // input polarity from the block
  input  wire logic [1:0][1:0]  in_sel,   // input selection from the block
  output var  acl_filt_s [1:0]  filt
);
  logic [1:0][15:0] lvl; // level the modulator sees
  // pins only when the block does not select an internal level
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      lvl[i] = (in_sel[i] == ACL_SEL_ZERO) ? ZERO_LVL : (in_sel[i] == ACL_SEL_FULL) ? FULL_LVL : pin_lvl[i];
    end
  end
  // idle word keeps toggling so a stale word never passes for a fresh one
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 2; i++) begin
      if (!aresetn) begin
        filt[i] <= '0;
      end else if (go[i]) begin
        filt[i].valid <= 1'b1;
        filt[i].word  <= lvl[i] + (chop_pol[i] ? -CHOP_D : CHOP_D);
      end else begin
        filt[i].valid <= 1'b0;
        filt[i].word  <= ~filt[i].word;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/acl_core_tb.sv
// self-checking bench for the chop and calibration logic
`timescale 1ns/1ps
`default_nettype none
module acl_core_tb;
  import acl_pkg::*;
  logic                      aclk, aresetn, ce, irq;           // clock, reset, enable, interrupt
  acl_filt_s [1:0]           filt;                             // words from the model
  logic [1:0]                chan_change, go, chop, bresp, rresp, resp;
  logic [1:0][1:0]           in_sel;                           // input selection seen
  logic [1:0][7:0]           rate;                             // decimation word to filters
  logic [1:0][15:0]          pin_lvl;                          // pin voltages
  logic [7:0]                awaddr, araddr;                   // bus addresses
  logic                      awvalid, awready, wvalid, wready, bvalid, bready;
  logic                      arvalid, arready, rvalid, rready;
  logic [31:0]               wdata, rdata, rd;                 // bus data, last read
  logic [3:0]                wstrb;                            // byte lanes
  int                        n_fail, n_tests;                  // mismatch and compare counts
  logic [7:0]                ofs_t [4] = '{ACL_OFS_OFF0, ACL_OFS_GAIN0, ACL_OFS_OFF0, ACL_OFS_GAIN0};
  logic [31:0]               exp_t [4] = '{32'h20, 32'h7000, 32'h40, 32'h6000}; // stored readings
  logic [15:0]               sys_t [4] = '{16'h5555, 16'h5555, 16'h0040, 16'h6000}; // pin levels
  logic [31:0]               sel_t [4] = '{32'h1, 32'h2, 32'h0, 32'h0};         // expected selection
  logic [2:0]                mode_t [4] = '{ACL_MODE_IZS, ACL_MODE_IFS, ACL_MODE_SZS, ACL_MODE_SFS};

  acl_core u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .filt(filt), .chan_change(chan_change),
    .fac_off({16'h0008, 16'hfff0}), .fac_gain({16'h7000, 16'h7fef}), .chop_pol_reg(chop),
    .in_sel_reg(in_sel), .rate_out_reg(rate), .irq_reg(irq), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
    .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
  acl_filt_model u_filt (.aclk(aclk), .aresetn(aresetn), .go(go), .pin_lvl(pin_lvl), .chop_pol(chop),
    .in_sel(in_sel), .filt(filt));

  // verdict and end of run, also reached when a wait bound runs out
  task automatic complete_run();
    $display("compares %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one comparison, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // handshakes are sampled at the falling edge, so the values match the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge aclk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) begin
        bready <= 1'b0;
        return;
      end
    end
    n_fail++;
    complete_run();
  endtask
  // read one word into rd and resp
  task automatic axi_rd(input logic [7:0] a);
    logic ah, rh;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge aclk);
      ah = arvalid & arready;
      rh = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      if (rh) begin
        rready <= 1'b0;
        return;
      end
    end
    n_fail++;
    complete_run();
  endtask
  // one filter word on each selected converter, then time to settle
  task automatic send(input logic [1:0] m);
    @(posedge aclk);
    go <= m;
    @(posedge aclk);
    go <= 2'b00;
    repeat (3) @(posedge aclk);
  endtask
  // expected scaled result: offset removed first, then normalized gain
  function automatic logic [31:0] scl(input longint x, input longint o, input longint g);
    longint n, q;
    n = (g > o) ? 64'sh3fff8000 / (g - o) : 64'sh8000;
    q = ((x - o) * n) >>> 15;
    if (q > 32767) q = 32767;
    if (q < -32768) q = -32768;
    return {16'h0000, q[15:0]};
  endfunction

  // free-running clock at 25 ns
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // main sequence
  initial begin
    {aresetn, chan_change, go, pin_lvl, awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    ce = 1'b1;
    wstrb = 4'hf;
    n_fail = 0;
    n_tests = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(ACL_OFS_RATE);
    chk(rd, 32'h45);
    axi_rd(ACL_OFS_OFF0);
    chk(rd & 32'hffff, 32'hfff0);
    axi_rd(ACL_OFS_GAIN1);
    chk(rd & 32'hffff, 32'h7000);
    axi_rd(8'h40);
    chk({rd[29:0], resp}, {30'h0, ACL_RESP_ERR});
    axi_wr(ACL_OFS_RES0, 32'h1234);
    chk(resp, ACL_RESP_ERR);
    axi_wr(ACL_OFS_RATE, 32'h05);
    chk(resp, ACL_RESP_OK);
    axi_rd(ACL_OFS_RATE);
    chk({rd[23:0], rate[0]}, {24'h0d, 8'h0d});
    $display("reset and rate test done");
    axi_wr(ACL_OFS_MASK, 32'h3);
    axi_wr(ACL_OFS_MODE, 32'h30);
    pin_lvl <= {16'h2000, 16'h1000};
    send(2'b11);
    axi_rd(ACL_OFS_STAT);
    chk(rd & 32'h3, 32'h0);
    send(2'b11);
    axi_rd(ACL_OFS_STAT);
    chk({rd[1:0], irq}, 3'b111);
    axi_rd(ACL_OFS_RES0);
    chk(rd & 32'hffff, scl(32'h1000, -16, 32'h7fef));
    axi_rd(ACL_OFS_RES0 + 8'h04);
    chk(rd & 32'hffff, scl(32'h2000, 8, 32'h7000));
    axi_wr(ACL_OFS_STAT, 32'h1);
    axi_rd(ACL_OFS_STAT);
    chk({rd[1:0], irq}, 3'b101);
    axi_wr(ACL_OFS_STAT, 32'h2);
    repeat (2) @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
    axi_wr(ACL_OFS_MASK, 32'h0);
    $display("conversion test done");
    // zero-scale always run before full-scale
    for (int k = 0; k < 4; k++) begin
      pin_lvl[0] <= sys_t[k];
      axi_wr(ACL_OFS_MODE, {28'h1, 1'b0, mode_t[k]});
      repeat (2) @(negedge aclk);
      chk({24'h0, rate[0]}, 32'hff);
      chk({30'h0, in_sel[0]}, sel_t[k]);
      axi_rd(ACL_OFS_STAT);
      chk(rd & 32'h13, 32'h10);
      send(2'b01);
      send(2'b01);
      axi_rd(ACL_OFS_STAT);
      chk({rd[0], irq}, 2'b10);
      axi_rd(ofs_t[k]);
      chk(rd & 32'hffff, exp_t[k]);
      axi_rd(ACL_OFS_MODE);
      chk(rd & 32'h7, 32'h0);
      axi_wr(ACL_OFS_STAT, 32'h3);
    end
    axi_rd(ACL_OFS_OFF0 + 8'h08);
    chk(rd & 32'hffff, 32'h0008);
    // auxiliary system full-scale, primary left alone
    pin_lvl[1] <= 16'h5000;
    axi_wr(ACL_OFS_MODE, 32'h27);
    send(2'b10);
    send(2'b10);
    axi_rd(ACL_OFS_GAIN1);
    chk(rd & 32'hffff, 32'h5000);
    axi_rd(ACL_OFS_GAIN0);
    chk(rd & 32'hffff, 32'h6000);
    $display("calibration test done");
    axi_wr(ACL_OFS_MODE, 32'h10);
    pin_lvl[0] <= 16'h3000;
    send(2'b01);
    // that first word after re-enable raises no flag; the primary flag is cleared so only a post-restart flag can show
    axi_wr(ACL_OFS_STAT, 32'h1);
    @(posedge aclk);
    chan_change <= 2'b01;
    @(posedge aclk);
    chan_change <= 2'b00;
    send(2'b01);
    axi_rd(ACL_OFS_STAT);
    chk(rd & 32'h1, 32'h0);
    send(2'b01);
    axi_rd(ACL_OFS_RES0);
    chk(rd & 32'hffff, scl(32'h3000, 32'h40, 32'h6000));
    $display("scaling test done");
    complete_run();
  end
endmodule
`default_nettype wire
